// ---- hdl/hdlc_tx_fifo_control.sv ----
`timescale 1ns/1ns
`include "hdlc_tx_map.svh"
module hdlc_tx_fifo_control
	import hdlc_tx_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// host data and commands
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	input wire tx_cmd_t cmd,
	input wire logic irq_status_rd,
	// configuration
	input wire logic tx_block_size_sel,
	input wire logic tx_crc_disable,
	input wire logic interframe_fill_sel,
	input wire logic d_slot_access_enable,
	input wire logic b1_slot_access_enable,
	input wire logic b2_slot_access_enable,
	input wire logic [2:0] link_irq_mask_reg,
	// status
	output logic [2:0] link_irq_status_reg,
	output logic tx_irq,
	output logic tx_overflow_flag,
	output logic tx_write_enable_flag,
	// serial highway
	input wire logic hw_frame_start,
	input wire logic hw_bit_strobe,
	input wire logic [1:0] hw_chan,
	input wire logic hw_collision,
	output logic tx_bit
);

	tx_regs_t r, n;
	logic tick, slot_en, errlock, free_ok, avail, in_frame, start, stuff, b;
	logic ev_xpr, ev_xdu, ev_xmr, do_cmd;
	logic [6:0] used;
	logic [5:0] last_idx;
	// flag pattern as a bit-indexable value, so each sent bit is a one-bit select
	localparam logic [7:0] flag_pat = `FLAG_BYTE;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic d);
		crc_step = (c >> 1) ^ (((c[0] ^ d)) ? `CRC_POLY : 16'h0000);
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// slot selection and derived conditions

	// [RULE_21] channel enables
	always_comb begin
		unique case (hw_chan)
			`CH_D: slot_en = d_slot_access_enable;
			`CH_B1: slot_en = b1_slot_access_enable;
			`CH_B2: slot_en = b2_slot_access_enable;
			default: slot_en = 1'b0;
		endcase
	end

	assign tick = hw_bit_strobe & slot_en;
	assign errlock = r.irq[`IRQ_XDU] | r.irq[`IRQ_XMR];
	// [RULE_01] 64-byte cyclic store
	assign used = r.wptr - r.rel;
	// [RULE_04] one block free
	assign free_ok = (`BUF_DEPTH - used) >= r.bs;
	assign avail = r.rptr != r.cptr;
	assign in_frame = (r.st == S_OPEN) | (r.st == S_DATA) | (r.st == S_CRC);
	// the first enabled slot after a highway frame start is the only start point
	assign start = tick & (r.sync | hw_frame_start) & avail & ~errlock;
	assign stuff = r.ones == `STUFF_ONES;
	assign do_cmd = (cmd.block_send | cmd.message_end) & ~errlock;

	//////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		n = r;
		ev_xpr = 1'b0;
		ev_xdu = 1'b0;
		ev_xmr = 1'b0;
		b = 1'b1;
		// [RULE_15] writes beyond the block still land, but flag overflow
		if (wr_valid && !errlock && !r.lock) begin
			n.mem[r.wptr[5:0]] = wr_data;
			n.eom[r.wptr[5:0]] = 1'b0;
			if (r.blk >= r.bs)
				n.ovf = 1'b1;
			else
				n.blk = r.blk + `PTR_ONE;
			// a full buffer overwrites its oldest byte
			if (used != `BUF_DEPTH)
				n.wptr = r.wptr + `PTR_ONE;
		end
		last_idx = n.wptr[5:0] - 6'h01;
		// [RULE_10] commit written bytes for transmission
		if (do_cmd) begin
			n.cptr = n.wptr;
			n.blk = 7'h00;
			// [RULE_11] end of message mark on the last written byte
			// [RULE_18] per-byte frame marks
			n.eom[last_idx] = cmd.message_end;
			// [RULE_17] block size latched only at a command
			n.bs = tx_block_size_sel ? `BLK_16 : `BLK_32;
			// [RULE_13] combined commands lock until the frame is out
			if (cmd.block_send && cmd.message_end)
				n.lock = 1'b1;
			else
				// [RULE_14] pool ready early
				n.armed = 1'b1;
		end
		if (hw_frame_start)
			n.sync = 1'b1;
		if (tick) begin
			n.sync = 1'b0;
			unique case (r.st)
				S_IDLE: begin
					// [RULE_20] interframe fill
					b = interframe_fill_sel ? flag_pat[r.bitc[2:0]] : 1'b1;
					n.bitc = {2'b00, r.bitc[2:0] + 3'h1};
					// [RULE_22] frame aligned start with opening flag
					if (start) begin
						b = flag_pat[3'h0];
						n.st = S_OPEN;
						n.bitc = 5'h01;
						n.crc = `CRC_INIT;
						n.fcnt = 8'h00;
						n.ones = 3'h0;
					end
				end
				S_OPEN: begin
					b = flag_pat[r.bitc[2:0]];
					n.bitc = r.bitc + 5'h01;
					if (r.bitc == `BYTE_LAST) begin
						n.st = S_DATA;
						n.bitc = 5'h00;
						n.sh = r.mem[r.rptr[5:0]];
						n.eom_cur = r.eom[r.rptr[5:0]];
						n.rptr = r.rptr + `PTR_ONE;
						n.fcnt = r.fcnt + 8'h01;
					end
				end
				S_DATA, S_CRC: begin
					if (stuff) begin
						b = 1'b0;
						n.ones = 3'h0;
					end else begin
						b = (r.st == S_DATA) ? r.sh[0] : ~r.crc[0];
						n.ones = b ? r.ones + 3'h1 : 3'h0;
						n.bitc = r.bitc + 5'h01;
						if (r.st == S_DATA) begin
							n.sh = r.sh >> 1;
							n.crc = crc_step(r.crc, b);
						end else begin
							n.crc = {1'b1, r.crc[15:1]};
						end
						if (r.st == S_CRC && r.bitc == `CRC_LAST) begin
							n.st = S_CLOSE;
							n.bitc = 5'h00;
						end
						if (r.st == S_DATA && r.bitc == `BYTE_LAST) begin
							n.bitc = 5'h00;
							if (r.eom_cur) begin
								// [RULE_19] CRC unless disabled
								n.st = tx_crc_disable ? S_CLOSE : S_CRC;
							end else if (avail) begin
								n.sh = r.mem[r.rptr[5:0]];
								n.eom_cur = r.eom[r.rptr[5:0]];
								n.rptr = r.rptr + `PTR_ONE;
								n.fcnt = (r.fcnt == `CNT_MAX) ? r.fcnt : r.fcnt + 8'h01;
							end else begin
								// [RULE_05] underrun aborts the frame
								n.st = S_ABORT;
								ev_xdu = 1'b1;
							end
						end
					end
				end
				S_CLOSE: begin
					// five ones at the frame end still need their zero before the flag
					if (stuff) begin
						b = 1'b0;
						n.ones = 3'h0;
					end else begin
						b = flag_pat[r.bitc[2:0]];
						n.bitc = r.bitc + 5'h01;
						if (r.bitc == `BYTE_LAST) begin
							n.st = S_IDLE;
							n.bitc = 5'h00;
							// [RULE_13] locked buffer released once the frame is sent
							if (r.lock) begin
								n.lock = 1'b0;
								n.armed = 1'b1;
							end
						end
					end
				end
				S_ABORT: begin
					// [RULE_05] seven ones
					b = 1'b1;
					n.bitc = r.bitc + 5'h01;
					if (r.bitc == `ABORT_LAST) begin
						n.st = S_IDLE;
						n.bitc = 5'h00;
					end
				end
				default: n.st = S_IDLE;
			endcase
			n.txd = b;
		end
		// [RULE_06] retry while the first block is still held
		if (hw_collision && in_frame) begin
			n.st = S_IDLE;
			n.bitc = 5'h00;
			if (r.fcnt <= {1'b0, r.bs})
				n.rptr = r.rel;
			else
				// [RULE_07] message repeat
				ev_xmr = 1'b1;
		end
		// first block stays held until the frame is past it
		if (!(in_frame && r.fcnt <= {1'b0, r.bs}))
			n.rel = n.rptr;
		// [RULE_09] underrun and repeat empty the buffer
		if (ev_xdu || ev_xmr) begin
			n.wptr = 7'h00;
			n.cptr = 7'h00;
			n.rptr = 7'h00;
			n.rel = 7'h00;
			n.blk = 7'h00;
			n.lock = 1'b0;
		end
		// [RULE_03] pool ready once a block of space is free
		if (r.armed && free_ok && !r.lock) begin
			ev_xpr = 1'b1;
			n.armed = 1'b0;
		end
		// [RULE_24] read clears what it returned, a new event wins
		n.irq = (r.irq & ~({3{irq_status_rd}} & r.irq)) | {ev_xmr, ev_xdu, ev_xpr};
		// [RULE_12] transmitter reset clears pointers, block count, lock, overflow and line state, not pending status
		if (cmd.reset) begin
			n.wptr = 7'h00;
			n.cptr = 7'h00;
			n.rptr = 7'h00;
			n.rel = 7'h00;
			n.blk = 7'h00;
			n.bs = tx_block_size_sel ? `BLK_16 : `BLK_32;
			n.lock = 1'b0;
			n.ovf = 1'b0;
			n.armed = 1'b1;
			n.st = S_IDLE;
			n.bitc = 5'h00;
			n.txd = 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// state register

	// [RULE_02] default block size is 32
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r <= '0;
			r.bs <= `BLK_32;
			r.st <= S_IDLE;
			r.txd <= 1'b1;
		end else begin
			r <= n;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// outputs

	assign link_irq_status_reg = r.irq;
	// [RULE_23] masked sources do not reach the interrupt line
	assign tx_irq = |(r.irq & ~link_irq_mask_reg);
	assign tx_overflow_flag = r.ovf;
	// [RULE_16] write enable tracks one free block
	assign tx_write_enable_flag = free_ok & ~r.lock & ~errlock;
	assign tx_bit = r.txd;

	//////////////////////////////////////////////////////////////////////////
	// checks

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence abort_entry_s;
		tick && r.st == S_DATA && !stuff && r.bitc == `BYTE_LAST && !r.eom_cur && !avail;
	endsequence

	sequence abort_out_s;
		r.st == S_ABORT && r.irq[`IRQ_XDU];
	endsequence

	reset_pool_ready_a: assert property (cmd.reset |-> ##2 r.irq[`IRQ_XPR]) // [RULE_03]
		else $error("no pool ready after transmitter reset");
	underrun_abort_a: assert property ((abort_entry_s and (!cmd.reset && !hw_collision))
		|=> abort_out_s) // [RULE_05]
		else $error("underrun did not abort");
	abort_ones_a: assert property (tick && r.st == S_ABORT && !cmd.reset |=> tx_bit) // [RULE_05]
		else $error("abort sent a zero");
	write_locked_a: assert property (errlock && !cmd.reset && !hw_collision
		|=> $stable(r.wptr)) // [RULE_09]
		else $error("write accepted while error pending");
	overflow_set_a: assert property (wr_valid && !errlock && !r.lock && r.blk >= r.bs
		&& !cmd.reset |=> tx_overflow_flag) // [RULE_15]
		else $error("overflow not flagged");
	size_hold_a: assert property (!cmd.block_send && !cmd.message_end && !cmd.reset
		|=> $stable(r.bs)) // [RULE_17]
		else $error("block size changed without command");
	combined_lock_a: assert property (cmd.block_send && cmd.message_end && !errlock
		&& !cmd.reset |=> r.lock && !tx_write_enable_flag) // [RULE_13]
		else $error("combined commands did not lock");
	idle_fill_a: assert property (tick && r.st == S_IDLE && !start && !interframe_fill_sel
		&& !cmd.reset |=> tx_bit) // [RULE_20]
		else $error("idle fill not ones");
	retry_rewind_a: assert property (hw_collision && in_frame && r.fcnt <= {1'b0, r.bs}
		&& !cmd.reset |=> r.rptr == $past(r.rel) && r.st == S_IDLE) // [RULE_06]
		else $error("retry did not rewind");
	mask_gate_a: assert property (r.irq[`IRQ_XMR] && !link_irq_mask_reg[`IRQ_XMR]
		|-> tx_irq) // [RULE_23]
		else $error("unmasked source not signalled");

endmodule

// ---- inc/hdlc_tx_map.svh ----
// Notes on behaviour
// [RULE_01] Transmit buffer is 64 bytes, cyclic; block size 16 or 32 by select bit.
// [RULE_02] Block size defaults to 32 bytes, select bit at zero.
// [RULE_03] Pool-ready raised after transmitter reset and when a sent block frees space.
// [RULE_04] Pool-ready means one block of space; any smaller byte count is accepted.
// [RULE_05] Buffer empty mid-frame aborts with seven ones and raises underrun.
// [RULE_06] Collision while first block still buffered retries the frame automatically.
// [RULE_07] Collision after first block raises message-repeat; host resends whole frame.
// [RULE_08] Host software never masks the message-repeat source.
// [RULE_09] Underrun and repeat reset buffer; writes ignored until status is read.
// [RULE_10] Block-send command sends buffered block, opening flag at frame start.
// [RULE_11] Message-end completes frame; CRC and closing flag appended.
// [RULE_12] Transmitter reset clears transmitter logic and all buffered data.
// [RULE_13] Send plus end locks buffer until frame sent; alone, pool-ready on space.
// [RULE_14] Block-send leaving space unused gives pool-ready at once and starts sending.
// [RULE_15] Writing past block size sets overflow; host must reset and restart.
// [RULE_16] Readable write-enable flag shows the buffer accepts data.
// [RULE_17] New block-size setting applies only at next send, end or reset command.
// [RULE_18] Buffer holds several complete frames while their total fits 64 bytes.
// [RULE_19] Host loads whole frame; CRC appended unless CRC-disable is set.
// [RULE_20] Between frames send flags or idle ones as configured.
// [RULE_21] Per-channel enables select D, B1, B2 slots singly or combined.
// [RULE_22] Transmission starts in the first enabled channel of a highway frame.
// [RULE_23] A status source is suppressed from the interrupt when its mask bit is one.
// [RULE_24] Reading the status clears the pool-ready, underrun and repeat bits returned.
`ifndef HDLC_TX_MAP_SVH
`define HDLC_TX_MAP_SVH
`define BUF_DEPTH 7'h40
`define BLK_32 7'h20
`define BLK_16 7'h10
`define PTR_ONE 7'h01
`define FLAG_BYTE 8'h7e
`define ABORT_LAST 5'h06
`define BYTE_LAST 5'h07
`define CRC_LAST 5'h0f
`define STUFF_ONES 3'h5
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h8408
`define CNT_MAX 8'hff
`define IRQ_XPR 0
`define IRQ_XDU 1
`define IRQ_XMR 2
`define CH_D 2'h0
`define CH_B1 2'h1
`define CH_B2 2'h2
`endif

// ---- inc/hdlc_tx_pkg.sv ----
package hdlc_tx_pkg;
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_OPEN = 6'h02,
		S_DATA = 6'h04,
		S_CRC = 6'h08,
		S_CLOSE = 6'h10,
		S_ABORT = 6'h20
	} tx_state_t;

	typedef struct packed {
		logic [63:0][7:0] mem;
		logic [63:0] eom;
		logic [6:0] wptr;
		logic [6:0] cptr;
		logic [6:0] rptr;
		logic [6:0] rel;
		logic [6:0] bs;
		logic [6:0] blk;
		logic [7:0] fcnt;
		logic armed;
		logic lock;
		logic ovf;
		logic eom_cur;
		logic sync;
		logic [2:0] irq;
		tx_state_t st;
		logic [7:0] sh;
		logic [4:0] bitc;
		logic [2:0] ones;
		logic [15:0] crc;
		logic txd;
	} tx_regs_t;

	typedef struct packed {
		logic block_send;
		logic message_end;
		logic reset;
	} tx_cmd_t;
endpackage

// ---- test/hdlc_highway_model.sv ----
`timescale 1ns/1ns
module hdlc_highway_model (
	// clock, reset and bench control
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic collide,
	// highway toward the block
	output logic hw_frame_start,
	output logic hw_bit_strobe,
	output logic [1:0] hw_chan,
	output logic hw_collision
);
	logic [2:0] div_r;
	logic [4:0] slot_r;

	////////////////////////////////////////////////////////////////
	// bit divider and 20-slot frame: B1 x8, B2 x8, D x2, unused x2
	always @(posedge clk) begin
		if (!rst_n) begin
			div_r <= 3'h0;
			slot_r <= 5'h0;
		end else begin
			div_r <= div_r + 3'h1;
			if (hw_bit_strobe) begin
				slot_r <= (slot_r == 5'h13) ? 5'h0 : slot_r + 5'h1;
			end
		end
	end

	// slow pacing stretches bit times, so the block must hold its output longer
	assign hw_bit_strobe = rst_n & (slow ? (div_r == 3'h7) : (div_r[1:0] == 2'h3));
	assign hw_frame_start = hw_bit_strobe & (slot_r == 5'h0);
	assign hw_chan = (slot_r < 5'h8) ? 2'h1 : (slot_r < 5'h10) ? 2'h2 :
		(slot_r < 5'h12) ? 2'h0 : 2'h3;
	// channel loss is only seen while a bit is on the wire
	assign hw_collision = collide & hw_bit_strobe;
endmodule

// ---- test/test_hdlc_tx_fifo_control.sv ----
`timescale 1ns/1ns
module test_hdlc_tx_fifo_control
	import hdlc_tx_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr_valid = 1'b0;
	logic [7:0] wr_data = 8'h00;
	tx_cmd_t cmd = 3'h0;
	logic rd = 1'b0;
	logic sel = 1'b0;
	logic crc_dis = 1'b0;
	logic [2:0] mask = 3'h0;
	logic slow = 1'b0;
	logic collide = 1'b0;
	logic fill = 1'b0;
	logic [2:0] st;
	logic irq, ovf, we, fs, bs, col, txb;
	logic [1:0] ch;
	logic [1:0] tick_r = 2'h0;
	logic got[$];
	logic exp_q[$];
	logic [7:0] dat[4];
	logic [15:0] crc;
	int n_fail = 0;
	int n_compared = 0;
	int seed = 32'h46b7;
	int ones;

	hdlc_tx_fifo_control i_hdlc_tx_fifo_control (
		.clk(clk), .rst_n(rst_n), .wr_valid(wr_valid), .wr_data(wr_data), .cmd(cmd),
		.irq_status_rd(rd), .tx_block_size_sel(sel), .tx_crc_disable(crc_dis),
		.interframe_fill_sel(fill), .d_slot_access_enable(1'b0),
		.b1_slot_access_enable(1'b1), .b2_slot_access_enable(1'b0),
		.link_irq_mask_reg(mask), .link_irq_status_reg(st), .tx_irq(irq),
		.tx_overflow_flag(ovf), .tx_write_enable_flag(we), .hw_frame_start(fs),
		.hw_bit_strobe(bs), .hw_chan(ch), .hw_collision(col), .tx_bit(txb));
	hdlc_highway_model i_hdlc_highway_model (
		.clk(clk), .rst_n(rst_n), .slow(slow), .collide(collide),
		.hw_frame_start(fs), .hw_bit_strobe(bs), .hw_chan(ch), .hw_collision(col));

	always #5 clk = ~clk;

	////////////////////////////////////////////////////////////////
	// capture the line two edges after each B1 tick, once it has settled
	always @(posedge clk) begin
		tick_r <= {tick_r[0], bs & (ch == 2'h1)};
		if (tick_r[1]) begin
			got.push_back(txb);
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic tally_and_finish;
		if (n_fail == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic clocks(input int n);
		repeat (n) @(posedge clk);
	endtask

	// byte writes, back to back; bytes past the table are random
	task automatic put(input int n);
		for (int i = 0; i < n; i++) begin
			wr_valid <= 1'b1;
			wr_data <= (i < 4) ? dat[i] : 8'($random(seed));
			@(posedge clk);
		end
		wr_valid <= 1'b0;
	endtask

	task automatic issue(input tx_cmd_t c);
		cmd <= c;
		@(posedge clk);
		cmd <= 3'h0;
	endtask

	// the value standing at the reading edge is what the read returns
	task automatic read_st(output logic [2:0] v);
		rd <= 1'b1;
		@(posedge clk);
		v = st;
		rd <= 1'b0;
	endtask

	task automatic wait_st(input int b, input int lim);
		int k = 0;
		while (st[b] !== 1'b1 && k < lim) begin
			@(posedge clk);
			k++;
		end
		// a timeout counts once and the run goes on to the closing report
		if (k == lim) begin
			n_fail++;
		end
	endtask

	////////////////////////////////////////////////////////////////
	// expected line image: reflected crc, zero after five ones, flags unstuffed
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			c = (c >> 1) ^ ((c[0] ^ d[i]) ? 16'h8408 : 16'h0000);
		end
		return c;
	endfunction

	task automatic add_bits(input logic [15:0] v, input int n, input bit stuff);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back(v[i]);
			ones = (stuff && v[i]) ? ones + 1 : 0;
			if (stuff && ones == 5) begin
				exp_q.push_back(1'b0);
				ones = 0;
			end
		end
	endtask

	// one locked frame; the closing flag's last zero anchors the compare,
	// so a retried first attempt left in the capture does not matter
	task automatic frame(input int n, input bit hit);
		logic [2:0] v;
		int p;
		read_st(v);
		exp_q = {};
		ones = 0;
		crc = 16'hffff;
		add_bits(16'h007e, 8, 1'b0);
		for (int i = 0; i < n; i++) begin
			add_bits({8'h00, dat[i]}, 8, 1'b1);
			crc = crc_byte(crc, dat[i]);
		end
		if (!crc_dis) begin
			add_bits(~crc, 16, 1'b1);
		end
		add_bits(16'h007e, 8, 1'b0);
		put(n);
		got = {};
		issue(3'h6);
		clocks(2);
		chk(we, 1'b0);
		if (hit) begin
			clocks(200);
			collide <= 1'b1;
			clocks(4);
			collide <= 1'b0;
		end
		wait_st(0, 20000);
		clocks(4);
		chk(st[2], 1'b0);
		p = got.size() - 1;
		while (p > 0 && got[p] !== 1'b0) p--;
		p = p - exp_q.size() + 1;
		for (int i = 0; i < exp_q.size(); i++) begin
			chk(got[p + i], exp_q[i]);
		end
	endtask

	initial begin
		logic [2:0] v;
		int p;
		for (int i = 0; i < 4; i++) begin
			dat[i] = 8'($random(seed));
		end
		// an all-ones byte forces stuffing inside the data
		dat[0] = 8'hff;
		clocks(2);
		rst_n <= 1'b1;
		clocks(1);
		chk({st, irq, ovf, we, txb}, 7'h03);
		mask <= 3'h1;
		issue(3'h1);
		clocks(4);
		chk({st[0], irq}, 2'h2);
		mask <= 3'h2;
		clocks(1);
		chk(irq, 1'b1);
		read_st(v);
		clocks(1);
		chk({v, st}, 6'h08);
		// size select waits for a command; 16-byte boundary after reset
		sel <= 1'b1;
		put(32);
		clocks(2);
		chk(ovf, 1'b0);
		issue(3'h1);
		put(16);
		clocks(2);
		chk(ovf, 1'b0);
		put(1);
		clocks(2);
		chk(ovf, 1'b1);
		sel <= 1'b0;
		issue(3'h1);
		clocks(4);
		chk(ovf, 1'b0);
		read_st(v);
		// open block that is never followed: pool ready at once, then underrun
		put(2);
		issue(3'h4);
		clocks(4);
		chk({st[0], we}, 2'h3);
		wait_st(1, 20000);
		clocks(2);
		chk(we, 1'b0);
		read_st(v);
		clocks(2);
		chk({v[1], we}, 2'h3);
		// long frame hit after its first block has left the buffer
		put(32);
		issue(3'h4);
		put(8);
		issue(3'h6);
		clocks(3000);
		collide <= 1'b1;
		clocks(4);
		collide <= 1'b0;
		wait_st(2, 100);
		clocks(2);
		chk(we, 1'b0);
		chk(irq, 1'b1);
		// flag fill on the quiet line: find a flag start, then expect 01111110
		fill <= 1'b1;
		got = {};
		clocks(300);
		fill <= 1'b0;
		p = 0;
		while (p < 8 && !(got[p] === 1'b0 && got[p + 1] === 1'b1)) begin
			p++;
		end
		for (int i = 0; i < 8; i++) begin
			chk(got[p + i], (8'h7e >> i) & 8'h01);
		end
		for (int r = 0; r < 2; r++) begin
			crc_dis <= r[0];
			slow <= r[0];
			clocks(1);
			frame(1 + ($random(seed) & 3), !r[0]);
		end
		tally_and_finish;
	end
endmodule
